// ### rtl/tbfsm_pkg.sv
package tbfsm_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] TBFSM_MON_ADDR = 8'h47;
    localparam logic [7:0] TBFSM_FRAME_ADDR = 8'h48;
    localparam logic [7:0] TBFSM_STATUS_ADDR = 8'hf0;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] TBFSM_MON_WMASK = 8'h8f;
    localparam logic [7:0] TBFSM_FRAME_WMASK = 8'hab;

    // values after reset
    localparam logic [7:0] TBFSM_MON_RST = 8'h00;
    localparam logic [7:0] TBFSM_FRAME_RST = 8'h00;

    // field positions
    localparam int TBFSM_FAST_IO_POS = 7;
    localparam int TBFSM_SEL_LSB = 0;
    localparam int TBFSM_HIGH_FIRST_POS = 7;
    localparam int TBFSM_ODD_PAR_POS = 5;
    localparam int TBFSM_STOP_LVL_POS = 3;
    localparam int TBFSM_START_LVL_POS = 1;
    localparam int TBFSM_START_EN_POS = 0;

    // status register field positions
    localparam int TBFSM_ST_BUSY_POS = 0;
    localparam int TBFSM_ST_DRIVE_POS = 1;
    localparam int TBFSM_ST_LEVEL_POS = 2;
    localparam int TBFSM_ST_LINE_POS = 3;
    localparam int TBFSM_ST_PINS_LSB = 4;

    // monitor select codes
    localparam logic [3:0] TBFSM_SEL_HIZ0 = 4'h0;
    localparam logic [3:0] TBFSM_SEL_HIZ1 = 4'h1;
    localparam logic [3:0] TBFSM_SEL_ZERO = 4'h2;
    localparam logic [3:0] TBFSM_SEL_ONE = 4'h3;
    localparam logic [3:0] TBFSM_SEL_TX_ENV = 4'h4;
    localparam logic [3:0] TBFSM_SEL_TX_ACT = 4'h5;
    localparam logic [3:0] TBFSM_SEL_SECURE = 4'h6;
    localparam logic [3:0] TBFSM_SEL_RX_ENV = 4'h7;
    localparam logic [3:0] TBFSM_SEL_RX_ACT = 4'h8;
    localparam logic [3:0] TBFSM_SEL_RX_BIT = 4'h9;

    // transmit bit timing at the system clock rate
    localparam int TBFSM_CLK_PERIOD_NS = 40;
    localparam int TBFSM_BIT_TIME_NS = 9434;
    localparam int TBFSM_BIT_CYCLES =
        (TBFSM_BIT_TIME_NS + TBFSM_CLK_PERIOD_NS - 1) / TBFSM_CLK_PERIOD_NS;
    localparam logic [7:0] TBFSM_BIT_LAST = 8'(TBFSM_BIT_CYCLES - 1);
    localparam logic [2:0] TBFSM_DATA_LAST = 3'h7;
    localparam int TBFSM_PIN_COUNT = 4;

    typedef struct packed {
        logic fast_io;
        logic [2:0] rsvd;
        logic [3:0] sel;
    } tbfsm_mon_reg_t;

    typedef struct packed {
        logic high_first;
        logic rsvd6;
        logic odd_parity;
        logic rsvd4;
        logic stop_level;
        logic rsvd2;
        logic start_level;
        logic start_enable;
    } tbfsm_frame_reg_t;

    typedef enum logic [2:0] {
        TBFSM_IDLE,
        TBFSM_START,
        TBFSM_DATA,
        TBFSM_PARITY,
        TBFSM_STOP
    } tbfsm_phase_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic val;
    } tbfsm_sync_st_t;

    typedef struct packed {
        tbfsm_mon_reg_t mon;
        tbfsm_frame_reg_t frame;
        tbfsm_frame_reg_t cfg;
        logic [7:0] rdata;
        tbfsm_phase_t phase;
        logic [7:0] shreg;
        logic [2:0] bit_idx;
        logic [7:0] bit_cnt;
        logic parity;
        logic line;
        logic active;
        logic mon_out;
        logic mon_oe_n;
    } tbfsm_state_t;

endpackage

// ### rtl/tbfsm_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tbfsm_sync
    import tbfsm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin side
    input wire logic pin_in,
    // filtered level
    output logic level_out
);

    tbfsm_sync_st_t state_ff;
    tbfsm_sync_st_t nxt_state;

    // s1 feeds only s2; a change is taken once s2 and s3 agree
    always_comb begin
        nxt_state = state_ff;
        nxt_state.s1 = pin_in;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        if (state_ff.s2 == state_ff.s3) begin
            nxt_state.val = state_ff.s3;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level_out = state_ff.val;

endmodule
`default_nettype wire

// ### rtl/tbfsm_top.sv
`timescale 1ns/1ns
`default_nettype none
module tbfsm_top
    import tbfsm_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // transmit byte stream
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    // transmit encoder output
    output logic TX_LINE,
    output logic TX_ACTIVE,
    // asynchronous monitor sources
    input wire logic SECURE_SERIAL_IN,
    input wire logic RX_ENVELOPE_IN,
    input wire logic RX_ACTIVE_IN,
    input wire logic RX_BIT_IN,
    // monitor output pin
    output logic MON_OUT,
    output logic MON_OE_N,
    // pad control
    output logic FAST_IO
);

    tbfsm_state_t state_ff;
    tbfsm_state_t nxt_state;

    logic [TBFSM_PIN_COUNT-1:0] pin_raw;
    logic [TBFSM_PIN_COUNT-1:0] pin_sync;
    logic secure_serial;
    logic rx_envelope;
    logic rx_active;
    logic rx_bit;
    logic bit_done;
    logic [7:0] status_word;

    // true when the select code puts a level on the pin
    function automatic logic mon_drives(input logic [3:0] sel);
        logic drv;
        drv = 1'b0;
        if (sel >= TBFSM_SEL_ZERO && sel <= TBFSM_SEL_RX_BIT) begin
            drv = 1'b1;
        end
        return drv;
    endfunction

    // data bit number idx in the configured order
    function automatic logic pick_bit(
        input logic [7:0] data,
        input logic [2:0] idx,
        input logic high_first
    );
        logic b;
        if (high_first) begin
            b = data[3'(TBFSM_DATA_LAST - idx)];
        end else begin
            b = data[idx];
        end
        return b;
    endfunction

    // monitor sources come from other domains and pass a filter
    assign pin_raw = {RX_BIT_IN, RX_ACTIVE_IN, RX_ENVELOPE_IN, SECURE_SERIAL_IN};

    generate
        for (genvar i = 0; i < TBFSM_PIN_COUNT; i++) begin : g_sync
            tbfsm_sync u_sync (
                .clk(SYS_CLK),
                .rst(RESET),
                .pin_in(pin_raw[i]),
                .level_out(pin_sync[i])
            );
        end
    endgenerate

    assign secure_serial = pin_sync[0];
    assign rx_envelope = pin_sync[1];
    assign rx_active = pin_sync[2];
    assign rx_bit = pin_sync[3];

    assign bit_done = (state_ff.bit_cnt == TBFSM_BIT_LAST);

    // status word gathers live state for software
    always_comb begin
        status_word = 8'h00;
        status_word[TBFSM_ST_BUSY_POS] = state_ff.active;
        status_word[TBFSM_ST_DRIVE_POS] = ~state_ff.mon_oe_n;
        status_word[TBFSM_ST_LEVEL_POS] = state_ff.mon_out;
        status_word[TBFSM_ST_LINE_POS] = state_ff.line;
        status_word[TBFSM_ST_PINS_LSB +: TBFSM_PIN_COUNT] = pin_sync;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = 8'h00;

        // register writes; reserved bits are masked off
        if (REG_WR) begin
            if (REG_ADDR == TBFSM_MON_ADDR) begin
                nxt_state.mon = tbfsm_mon_reg_t'(REG_WDATA & TBFSM_MON_WMASK);
            end
            if (REG_ADDR == TBFSM_FRAME_ADDR) begin
                nxt_state.frame = tbfsm_frame_reg_t'(REG_WDATA & TBFSM_FRAME_WMASK);
            end
        end

        // register reads; data stands only in the next cycle
        if (REG_RD) begin
            unique case (REG_ADDR)
                TBFSM_MON_ADDR: begin
                    nxt_state.rdata = state_ff.mon & TBFSM_MON_WMASK;
                end
                TBFSM_FRAME_ADDR: begin
                    nxt_state.rdata = state_ff.frame & TBFSM_FRAME_WMASK;
                end
                TBFSM_STATUS_ADDR: begin
                    nxt_state.rdata = status_word;
                end
                default: begin
                    nxt_state.rdata = 8'h00;
                end
            endcase
        end

        // transmit encoder
        // framing is latched per byte, so a late write only hits the next byte
        unique case (state_ff.phase)
            TBFSM_IDLE: begin
                nxt_state.line = 1'b0;
                nxt_state.active = 1'b0;
                if (TX_VALID) begin
                    nxt_state.cfg = state_ff.frame;
                    nxt_state.shreg = TX_DATA;
                    nxt_state.bit_idx = 3'h0;
                    nxt_state.bit_cnt = 8'h00;
                    nxt_state.active = 1'b1;
                    nxt_state.parity = (^TX_DATA) ^ state_ff.frame.odd_parity;
                    if (state_ff.frame.start_enable) begin
                        nxt_state.phase = TBFSM_START;
                        nxt_state.line = state_ff.frame.start_level;
                    end else begin
                        nxt_state.phase = TBFSM_DATA;
                        nxt_state.line = pick_bit(TX_DATA, 3'h0,
                            state_ff.frame.high_first);
                    end
                end
            end
            TBFSM_START: begin
                if (bit_done) begin
                    nxt_state.bit_cnt = 8'h00;
                    nxt_state.phase = TBFSM_DATA;
                    nxt_state.line = pick_bit(state_ff.shreg, 3'h0,
                        state_ff.cfg.high_first);
                end else begin
                    nxt_state.bit_cnt = 8'(state_ff.bit_cnt + 8'h01);
                end
            end
            TBFSM_DATA: begin
                if (bit_done) begin
                    nxt_state.bit_cnt = 8'h00;
                    if (state_ff.bit_idx == TBFSM_DATA_LAST) begin
                        nxt_state.phase = TBFSM_PARITY;
                        nxt_state.line = state_ff.parity;
                    end else begin
                        nxt_state.bit_idx = 3'(state_ff.bit_idx + 3'h1);
                        nxt_state.line = pick_bit(state_ff.shreg,
                            3'(state_ff.bit_idx + 3'h1),
                            state_ff.cfg.high_first);
                    end
                end else begin
                    nxt_state.bit_cnt = 8'(state_ff.bit_cnt + 8'h01);
                end
            end
            TBFSM_PARITY: begin
                if (bit_done) begin
                    nxt_state.bit_cnt = 8'h00;
                    nxt_state.phase = TBFSM_STOP;
                    nxt_state.line = state_ff.cfg.stop_level;
                end else begin
                    nxt_state.bit_cnt = 8'(state_ff.bit_cnt + 8'h01);
                end
            end
            TBFSM_STOP: begin
                if (bit_done) begin
                    nxt_state.bit_cnt = 8'h00;
                    nxt_state.phase = TBFSM_IDLE;
                    nxt_state.line = 1'b0;
                    nxt_state.active = 1'b0;
                end else begin
                    nxt_state.bit_cnt = 8'(state_ff.bit_cnt + 8'h01);
                end
            end
            default: begin
                // unused phase codes fall back to idle rather than lock up
                nxt_state.phase = TBFSM_IDLE;
                nxt_state.bit_cnt = 8'h00;
                nxt_state.line = 1'b0;
                nxt_state.active = 1'b0;
            end
        endcase

        // monitor pin, registered so the pad sees no decode glitches
        nxt_state.mon_oe_n = ~mon_drives(state_ff.mon.sel);
        case (state_ff.mon.sel)
            TBFSM_SEL_HIZ0, TBFSM_SEL_HIZ1: begin
                nxt_state.mon_out = 1'b0;
            end
            TBFSM_SEL_ZERO: begin
                nxt_state.mon_out = 1'b0;
            end
            TBFSM_SEL_ONE: begin
                nxt_state.mon_out = 1'b1;
            end
            TBFSM_SEL_TX_ENV: begin
                nxt_state.mon_out = state_ff.line;
            end
            TBFSM_SEL_TX_ACT: begin
                nxt_state.mon_out = state_ff.active;
            end
            TBFSM_SEL_SECURE: begin
                nxt_state.mon_out = secure_serial;
            end
            TBFSM_SEL_RX_ENV: begin
                // only meaningful for type A at 106 kBd
                nxt_state.mon_out = rx_envelope;
            end
            TBFSM_SEL_RX_ACT: begin
                nxt_state.mon_out = rx_active;
            end
            TBFSM_SEL_RX_BIT: begin
                nxt_state.mon_out = rx_bit;
            end
            default: begin
                // reserved codes leave the pin floating
                nxt_state.mon_out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_ff.mon <= tbfsm_mon_reg_t'(TBFSM_MON_RST);
            state_ff.frame <= tbfsm_frame_reg_t'(TBFSM_FRAME_RST);
            state_ff.cfg <= tbfsm_frame_reg_t'(TBFSM_FRAME_RST);
            state_ff.rdata <= 8'h00;
            state_ff.phase <= TBFSM_IDLE;
            state_ff.shreg <= 8'h00;
            state_ff.bit_idx <= 3'h0;
            state_ff.bit_cnt <= 8'h00;
            state_ff.parity <= 1'b0;
            state_ff.line <= 1'b0;
            state_ff.active <= 1'b0;
            state_ff.mon_out <= 1'b0;
            state_ff.mon_oe_n <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs
    assign REG_RDATA = state_ff.rdata;
    assign TX_READY = (state_ff.phase == TBFSM_IDLE);
    assign TX_LINE = state_ff.line;
    assign TX_ACTIVE = state_ff.active;
    assign MON_OUT = state_ff.mon_out;
    assign MON_OE_N = state_ff.mon_oe_n;
    assign FAST_IO = state_ff.mon.fast_io;

endmodule
`default_nettype wire

// ### dv/tbfsm_props.sv
`timescale 1ns/1ns
`default_nettype none
module tbfsm_props
    import tbfsm_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // transmit side
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_LINE,
    input wire logic TX_ACTIVE,
    // pins
    input wire logic MON_OUT,
    input wire logic MON_OE_N,
    input wire logic FAST_IO
);
    // shadow copies of both registers; sel_d_ff lines up with the registered pin
    logic [7:0] mon_ff, frame_ff, cfg_ff, data_ff;
    logic [3:0] sel_d_ff;
    logic [11:0] len_ff;
    wire logic mon_wr = REG_WR && REG_ADDR == TBFSM_MON_ADDR;
    wire logic frm_wr = REG_WR && REG_ADDR == TBFSM_FRAME_ADDR;
    wire logic accept = TX_VALID && TX_READY;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            mon_ff <= TBFSM_MON_RST;
            frame_ff <= TBFSM_FRAME_RST;
            cfg_ff <= 8'h00;
            data_ff <= 8'h00;
            sel_d_ff <= 4'h0;
            len_ff <= 12'h000;
        end else begin
            if (mon_wr) mon_ff <= REG_WDATA & TBFSM_MON_WMASK;
            if (frm_wr) frame_ff <= REG_WDATA & TBFSM_FRAME_WMASK;
            if (accept) cfg_ff <= frame_ff;
            if (accept) data_ff <= TX_DATA;
            sel_d_ff <= mon_ff[3:0];
            len_ff <= accept ? 12'h000 : len_ff + 12'(TX_ACTIVE);
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    sequence s_accept;
        TX_VALID && TX_READY;
    endsequence
    sequence s_mon_wr_once;
        mon_wr ##1 !mon_wr;
    endsequence
    chk_fast_io_set: assert property (s_mon_wr_once |=> FAST_IO == $past(REG_WDATA[7], 2))
        else $error("fast pad switching does not follow the register");
    chk_float_codes: assert property ((sel_d_ff < 4'h2 || sel_d_ff > 4'h9) |-> MON_OE_N && !MON_OUT)
        else $error("monitor pin driven on a floating code");
    chk_const_drive: assert property ((sel_d_ff == 4'h2 || sel_d_ff == 4'h3)
        |-> !MON_OE_N && MON_OUT == sel_d_ff[0])
        else $error("monitor pin constant level wrong");
    chk_tx_mirror: assert property ((sel_d_ff == 4'h4 || sel_d_ff == 4'h5) |-> !MON_OE_N
        && MON_OUT == (sel_d_ff[0] ? $past(TX_ACTIVE) : $past(TX_LINE)))
        else $error("monitor pin does not show the transmitter");
    chk_mon_readback: assert property ($past(REG_RD) && $past(REG_ADDR) == TBFSM_MON_ADDR
        |-> REG_RDATA == $past(mon_ff))
        else $error("monitor register read back wrong");
    chk_frame_readback: assert property ($past(REG_RD) && $past(REG_ADDR) == TBFSM_FRAME_ADDR
        |-> REG_RDATA == $past(frame_ff))
        else $error("framing register read back wrong");
    chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data stands outside its cycle");
    chk_frame_first: assert property (s_accept |=> TX_ACTIVE && !TX_READY && TX_LINE ==
        (cfg_ff[0] ? cfg_ff[1] : (cfg_ff[7] ? data_ff[7] : data_ff[0])))
        else $error("first transmitted bit wrong");
    chk_frame_len: assert property ($fell(TX_ACTIVE)
        |-> len_ff == 12'(TBFSM_BIT_CYCLES * (cfg_ff[0] ? 11 : 10)))
        else $error("frame length wrong");
    chk_stop_level: assert property ($fell(TX_ACTIVE)
        |-> $past(TX_LINE) == cfg_ff[3] && !TX_LINE && TX_READY)
        else $error("stop bit level wrong");
endmodule
bind tbfsm_top tbfsm_props u_props (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_LINE(TX_LINE),
    .TX_ACTIVE(TX_ACTIVE), .MON_OUT(MON_OUT), .MON_OE_N(MON_OE_N), .FAST_IO(FAST_IO));
`default_nettype wire

// ### dv/tbfsm_host.sv
`timescale 1ns/1ns
`default_nettype none
module tbfsm_host
    import tbfsm_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata,
    // transmitter state
    input wire logic tx_busy
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // released lines show the inverse so a stale value is never mistaken for a live one
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        if (a == TBFSM_FRAME_ADDR && tx_busy !== 1'b0) return;
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        // read data stands only in this cycle, so take it mid-cycle
        @(negedge clk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ### dv/test_tbfsm_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_tbfsm_top
    import tbfsm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data;
    logic reg_wr, reg_rd, tx_valid, tx_ready, tx_line, tx_active, mon_out, mon_oe_n, fast_io;
    logic [3:0] src = 4'h0;
    logic [7:0] cfg_tab [4] = '{8'h00, 8'hab, 8'h81, 8'h2a};
    int err_total = 0;
    int checks = 0;
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    tbfsm_top uut (.SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TX_DATA(tx_data),
        .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_LINE(tx_line), .TX_ACTIVE(tx_active),
        .SECURE_SERIAL_IN(src[0]), .RX_ENVELOPE_IN(src[1]), .RX_ACTIVE_IN(src[2]),
        .RX_BIT_IN(src[3]), .MON_OUT(mon_out), .MON_OE_N(mon_oe_n), .FAST_IO(fast_io));
    tbfsm_host host (.clk(sys_clk), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr),
        .rd(reg_rd), .rdata(reg_rdata), .tx_busy(tx_active));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // returns {output enable low, pin level}; codes 4 and 5 assume an idle transmitter
    function automatic logic [1:0] mon_exp(input logic [3:0] c, input logic [3:0] s);
        case (c)
            4'h2: return 2'b00;
            4'h3: return 2'b01;
            4'h4, 4'h5: return 2'b00;
            4'h6: return {1'b0, s[0]};
            4'h7: return {1'b0, s[1]};
            4'h8: return {1'b0, s[2]};
            4'h9: return {1'b0, s[3]};
            default: return 2'b10;
        endcase
    endfunction
    function automatic logic frame_bit(input logic [7:0] cfg, input logic [7:0] d, input int j);
        int k;
        k = j - int'(cfg[0]);
        if (cfg[0] && j == 0) return cfg[1];
        if (k < 8) return cfg[7] ? d[7 - k] : d[k];
        if (k == 8) return ^d ^ cfg[5];
        return cfg[3];
    endfunction
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end
    initial begin
        logic [7:0] rd_v, cfg, dat;
        logic [3:0] c;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        void'($urandom(95));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        host.reg_read(TBFSM_MON_ADDR, rd_v);
        check(rd_v, TBFSM_MON_RST);
        host.reg_read(TBFSM_FRAME_ADDR, rd_v);
        check(rd_v, TBFSM_FRAME_RST);
        host.reg_write(8'h10, 8'hff);
        host.reg_read(8'h10, rd_v);
        check(rd_v, 8'h00);
        host.reg_write(TBFSM_FRAME_ADDR, 8'hff);
        host.reg_read(TBFSM_FRAME_ADDR, rd_v);
        check(rd_v, 8'hab);
        // every select code, reserved bits set at random, sources held still
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            dat = 8'($urandom);
            host.reg_write(TBFSM_MON_ADDR, {dat[7:4], c});
            src <= dat[3:0];
            repeat (10) @(posedge sys_clk);
            check({5'h00, fast_io, mon_oe_n, mon_out}, {5'h00, dat[7], mon_exp(c, dat[3:0])});
            host.reg_read(TBFSM_MON_ADDR, rd_v);
            check(rd_v, {dat[7], 3'h0, c});
        end
        // status is read only; pins settled, transmitter idle, pin floating
        host.reg_write(TBFSM_STATUS_ADDR, 8'hff);
        host.reg_read(TBFSM_STATUS_ADDR, rd_v);
        check(rd_v, {src, 4'h0});
        // frames sampled mid-bit; pin shows envelope or activity meanwhile
        for (int i = 0; i < 6; i++) begin
            cfg = i < 4 ? cfg_tab[i] : 8'($urandom);
            dat = 8'($urandom);
            host.reg_write(TBFSM_MON_ADDR, {7'h02, i[0]});
            host.reg_write(TBFSM_FRAME_ADDR, cfg);
            tx_data <= dat;
            tx_valid <= 1'b1;
            @(negedge sys_clk);
            check({7'h00, tx_ready}, 8'h01);
            @(posedge sys_clk);
            tx_valid <= 1'b0;
            tx_data <= ~dat;
            @(negedge sys_clk);
            check({6'h00, tx_ready, tx_active}, 8'h01);
            repeat (TBFSM_BIT_CYCLES / 2) @(posedge sys_clk);
            for (int j = 0; j < 10 + int'(cfg[0]); j++) begin
                check({6'h00, tx_active, tx_line}, {7'h01, frame_bit(cfg, dat, j)});
                repeat (TBFSM_BIT_CYCLES) @(posedge sys_clk);
            end
            check({5'h00, tx_ready, tx_active, tx_line}, 8'h04);
        end
        stop_test();
    end
endmodule
`default_nettype wire
